// >>> hdl/reset_sequence_manager.sv
// module: reset sequence manager top
// Operation
// - pin, low voltage, watchdog each start reset
// - every cause drives pin; low during delay
// - phases: active, delay, then vector fetch
// - delay 256 or 4096 cycles, option selected
// - vector fetch two cycles from FFFE-FFFF
// - open-drain pin, driven only low
// - pin low caught asynchronously, even halted
`timescale 1ns/1ps
module reset_sequence_manager #(
  parameter int unsigned DELAY_SHORT = rsm_pkg::DELAY_SHORT_CYC,
  parameter int unsigned DELAY_LONG  = rsm_pkg::DELAY_LONG_CYC
) (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        rst_pin_in,
  output logic             rst_pin_out,
  output logic             rst_pin_oe_out,
  input  wire logic        low_voltage_detect_in,
  input  wire logic        wdg_rst_in,
  input  wire logic        opt_long_delay_in,
  output logic             cpu_rst_n_out,
  output logic             vec_fetch_out,
  output logic [15:0]      vec_addr_out,
  output rsm_pkg::rsm_state_e phase_out
);
  import rsm_pkg::*;

  rsm_cause_if cif ();
  rsm_state_e        st_r, st_nxt;
  logic [CNT_W-1:0]  cnt_r, cnt_nxt;
  logic              oe_r, oe_nxt;
  logic              crn_r, crn_nxt;
  logic              vf_r, vf_nxt;
  logic [15:0]       va_r, va_nxt;

  // pin seen low externally (we never read our own drive as a cause)
  rsm_cause_catch u_catch (
    .clk_in     (clk_in),
    .nrst_in    (nrst_in),
    .pin_low_in (~rst_pin_in & ~oe_r),
    .lvd_in     (low_voltage_detect_in),
    .wdg_in     (wdg_rst_in),
    .c          (cif.catcher)
  );

  function automatic logic [CNT_W-1:0] delay_len(input logic long_sel);
    delay_len = long_sel ? CNT_W'(DELAY_LONG - 1) : CNT_W'(DELAY_SHORT - 1);
  endfunction

  // phase sequencing
  always_comb begin
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    oe_nxt  = 1'b0;
    crn_nxt = 1'b0;
    vf_nxt  = 1'b0;
    va_nxt  = ADDR_IDLE;
    if (cif.any_cause) begin
      st_nxt  = RSM_ACTIVE;
      cnt_nxt = '0;
      oe_nxt  = 1'b1;
    end else begin
      case (st_r)
        RSM_ACTIVE: begin
          st_nxt  = RSM_DELAY;
          cnt_nxt = delay_len(opt_long_delay_in);
          oe_nxt  = 1'b1;
        end
        RSM_DELAY: begin
          oe_nxt = 1'b1;
          if (cnt_r == '0) begin
            st_nxt  = RSM_FETCH;
            cnt_nxt = CNT_W'(FETCH_CYC - 1);
            oe_nxt  = 1'b0;
            vf_nxt  = 1'b1;
            va_nxt  = VEC_ADDR_HI;
          end else begin
            cnt_nxt = cnt_r - 1'b1;
          end
        end
        RSM_FETCH: begin
          if (cnt_r == '0) begin
            st_nxt  = RSM_RUN;
            crn_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r - 1'b1;
            vf_nxt  = 1'b1;
            va_nxt  = VEC_ADDR_LO;
          end
        end
        RSM_RUN: begin
          crn_nxt = 1'b1;
        end
        default: begin
          st_nxt = RSM_ACTIVE;
          oe_nxt = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      st_r  <= RSM_ACTIVE;
      cnt_r <= '0;
      oe_r  <= 1'b1;
      crn_r <= 1'b0;
      vf_r  <= 1'b0;
      va_r  <= ADDR_IDLE;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
      oe_r  <= oe_nxt;
      crn_r <= crn_nxt;
      vf_r  <= vf_nxt;
      va_r  <= va_nxt;
    end
  end

  assign rst_pin_out    = 1'b0;
  assign rst_pin_oe_out = oe_r;
  assign cpu_rst_n_out  = crn_r;
  assign vec_fetch_out  = vf_r;
  assign vec_addr_out   = va_r;
  assign phase_out      = st_r;
endmodule // reset_sequence_manager

// >>> common/rsm_pkg.sv
// package: constants and types of the reset sequence manager
package rsm_pkg;
  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned DELAY_SHORT_CYC  = 256;
  localparam int unsigned DELAY_LONG_CYC   = 4096;
  localparam int unsigned FETCH_CYC        = 2;
  localparam int unsigned CNT_W            = 13;
  localparam logic [15:0] VEC_ADDR_HI      = 16'hFFFE;
  localparam logic [15:0] VEC_ADDR_LO      = 16'hFFFF;
  localparam logic [15:0] ADDR_IDLE        = 16'h0000;
  localparam logic [2:0]  CAUSE_NONE       = 3'h0;

  // sequence phases, one-hot
  typedef enum logic [3:0] {
    RSM_ACTIVE = 4'b0001,
    RSM_DELAY  = 4'b0010,
    RSM_FETCH  = 4'b0100,
    RSM_RUN    = 4'b1000
  } rsm_state_e;
endpackage

// >>> common/rsm_cause_if.sv
// interface: reset causes between the catcher and the sequencer
`timescale 1ns/1ps
interface rsm_cause_if;
  logic       any_cause;
  logic [2:0] cause;
  modport catcher (output any_cause, output cause);
  modport seq     (input any_cause, input cause);
endinterface

// >>> hdl/rsm_cause_catch.sv
// module: catch of reset causes, pin cause asynchronous, low voltage and watchdog clocked
`timescale 1ns/1ps
module rsm_cause_catch (
  input  wire logic   clk_in,
  input  wire logic   nrst_in,
  input  wire logic   pin_low_in,
  input  wire logic   lvd_in,
  input  wire logic   wdg_in,
  rsm_cause_if.catcher c
);
  import rsm_pkg::*;
  logic [2:0] raw;
  logic [2:0] hold_r;
  logic [2:0] hold_nxt;
  logic       pin_nrst;

  // external pin low resets the catch flop with no clock needed
  assign pin_nrst = nrst_in & ~pin_low_in;
  assign raw      = {wdg_in, lvd_in, pin_low_in};

  // latched cause bits, pin bit forced asynchronously
  always_comb begin
    hold_nxt = raw;
  end

  always_ff @(posedge clk_in or negedge pin_nrst) begin
    if (!pin_nrst) begin
      hold_r <= 3'h1;
    end else begin
      hold_r <= hold_nxt;
    end
  end

  assign c.cause     = hold_r;
  assign c.any_cause = |hold_r;
endmodule // rsm_cause_catch

// >>> sim/rsm_ext_model.sv
// model: external reset circuit on the pulled-up pin
`timescale 1ns/1ps
module rsm_ext_model (
  input  logic oe_in,
  input  logic low_in,
  output logic pin_out
);
  // low if either side pulls, else pull-up
  assign pin_out = !(oe_in || low_in);
endmodule // rsm_ext_model

// >>> sim/rsm_checker.sv
// checker: reset sequence timing
`timescale 1ns/1ps
module rsm_checker import rsm_pkg::*; #(int DELAY_SHORT = 8, DELAY_LONG = 32) (
  input logic clk_in, nrst_in, rst_pin_in, rst_pin_out, rst_pin_oe_out, wdg_rst_in,
  input logic low_voltage_detect_in, opt_long_delay_in, cpu_rst_n_out, vec_fetch_out,
  input logic [15:0] vec_addr_out,
  input rsm_state_e phase_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  logic [12:0] n_r, n_nxt;
  // count of delay cycles
  always_comb n_nxt = phase_out == RSM_DELAY ? n_r + 13'h1 : 13'h0;
  always_ff @(posedge clk_in or negedge nrst_in)
    if (!nrst_in) n_r <= 13'h0;
    else n_r <= n_nxt;
  sequence vec_s;
    vec_addr_out == VEC_ADDR_HI ##1 vec_fetch_out && vec_addr_out == VEC_ADDR_LO;
  endsequence
  pin_od_a: assert property (!rst_pin_out) else $error("pin high");
  cause_seen_a: assert property (wdg_rst_in || low_voltage_detect_in |-> ##[1:2]
    phase_out == RSM_ACTIVE) else $error("no start");
  delay_oe_a: assert property (phase_out == RSM_DELAY |->
    rst_pin_oe_out) else $error("pin free");
  phase_order_a: assert property (phase_out == RSM_FETCH |->
    $past(phase_out) inside {RSM_DELAY, RSM_FETCH}) else $error("order");
  delay_len_a: assert property ($fell(phase_out == RSM_DELAY) &&
    phase_out == RSM_FETCH |-> n_r == (opt_long_delay_in ? DELAY_LONG : DELAY_SHORT))
    else $error("delay");
  vec_fetch_a: assert property (
    disable iff (!nrst_in || wdg_rst_in || low_voltage_detect_in)
    $rose(vec_fetch_out) |-> vec_s ##1 cpu_rst_n_out) else $error("vector");
  pin_async_a: assert property (!rst_pin_in && !rst_pin_oe_out |=>
    phase_out == RSM_ACTIVE) else $error("pin lost");
  rst_release_a: assert property ($rose(cpu_rst_n_out) |->
    $past(vec_fetch_out, 1) && $past(vec_fetch_out, 2)) else $error("release");
endmodule // rsm_checker
bind reset_sequence_manager rsm_checker #(.DELAY_SHORT(DELAY_SHORT),
  .DELAY_LONG(DELAY_LONG)) CHK (.*);

// >>> sim/tb_top.sv
// bench: reset sequence manager with external reset circuit
`timescale 1ns/1ps
module tb_top;
  import rsm_pkg::*;
  logic clk_in = 0, nrst_in = 0, w = 0, l = 0, p = 0, o = 0, pin, oe, crn, vf, pdrv;
  logic [15:0] a;
  rsm_state_e ph;
  int errors = 0, total_checks = 0, cyc = 0;
  always #10 clk_in = ~clk_in;
  rsm_ext_model PART (.oe_in(oe), .low_in(p), .pin_out(pin));
  reset_sequence_manager #(.DELAY_SHORT(8), .DELAY_LONG(32)) DUT (.clk_in, .nrst_in,
    .rst_pin_in(pin), .rst_pin_out(pdrv), .rst_pin_oe_out(oe), .low_voltage_detect_in(l),
    .wdg_rst_in(w), .opt_long_delay_in(o), .cpu_rst_n_out(crn), .vec_fetch_out(vf),
    .vec_addr_out(a), .phase_out(ph));
  task automatic chk(string n, logic [15:0] e, g);
    total_checks++;
    if (g !== e) $display("MISMATCH %s exp %h got %h", n, e, g);
    errors += g !== e;
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hold causes until the start, then follow one sequence
  task automatic kick(logic [3:0] c, int n, int d = 0);
    {w, l, p, o} = c;
    while (ph !== RSM_ACTIVE) @(negedge clk_in);
    {w, l, p} = 3'h0;
    while (ph !== RSM_DELAY) @(negedge clk_in);
    chk("oe", 1, oe);
    for (; ph === RSM_DELAY; d++) @(negedge clk_in);
    chk("delay", n, d);
    chk("hi", VEC_ADDR_HI, a);
    chk("fetch", 1, vf);
    @(negedge clk_in);
    chk("lo", VEC_ADDR_LO, a);
    chk("fetch2", 1, vf);
    @(negedge clk_in);
    chk("run", 1, crn);
    chk("free", 0, oe);
    chk("drive", 0, pdrv);
  endtask
  // reset, watchdog, low-voltage and pin causes, then a watchdog pulse and a low-voltage cause from mid-delay that restarts the sequence
  initial begin
    repeat (12) @(negedge clk_in);
    nrst_in = 1;
    kick(4'h0, 8);
    kick(4'h9, 32);
    kick(4'h4, 8);
    kick(4'h3, 32);
    w = 1;
    @(negedge clk_in);
    w = 0;
    repeat (6) @(negedge clk_in);
    kick(4'h4, 8);
    end_sim();
  end
  // cuts a hung run short
  always @(posedge clk_in) begin
    cyc++;
    if (cyc > 2000) begin
      errors++;
      end_sim();
    end
  end
endmodule // tb_top
